/* verilog/occ_pkg.sv */
// Contract
// - Bit 7 reads live comparator result
// - Bit 6 selects comparator offset cancellation
// - Bit 5 selects comparator calibration reference
// - Bits 4..0 comparator trim, reset 10000
// - Mode 11, amp flag only: amp calibration
// - Mode 11, comparator flag only: comparator calibration
// - Mode decode; disabled forces comparator low
// - Amp register bit 7 selects calibration
// - Amp trim bits 5..0, reset 100000
package occ_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OCC_ADDR_CTRL = 8'h00; // Mode control
    localparam logic [7:0] OCC_ADDR_AMP  = 8'h04; // Amplifier cal
    localparam logic [7:0] OCC_ADDR_CMP  = 8'h08; // Comparator cal

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int OCC_CTRL_MODE_LSB = 0;  // Mode field low bit
    localparam int OCC_CMP_RES_BIT   = 7;  // Comparator result
    localparam int OCC_CMP_MODE_BIT  = 6;  // Comparator cal mode
    localparam int OCC_CMP_REF_BIT   = 5;  // Comparator ref select
    localparam int OCC_AMP_MODE_BIT  = 7;  // Amplifier cal mode
    localparam int OCC_AMP_REF_BIT   = 6;  // Amplifier ref select

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [4:0] OCC_CMP_TRIM_RST = 5'h10; // Mid scale
    localparam logic [5:0] OCC_AMP_TRIM_RST = 6'h20; // Mid scale
    localparam logic [1:0] OCC_MODE_RST     = 2'h0;  // Disabled

    // ------------------------------------------------------------
    // Synchroniser depth
    // ------------------------------------------------------------
    localparam int OCC_SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Protection modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OCC_MODE_OFF = 2'h0,  // Disabled
        OCC_MODE_NON = 2'h1,  // Non-inverting
        OCC_MODE_INV = 2'h2,  // Inverting
        OCC_MODE_CAL = 2'h3   // Calibration
    } occ_mode_t;

    // ------------------------------------------------------------
    // Front end operating state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        OCC_ST_NORMAL  = 2'h0, // Normal protection
        OCC_ST_AMPCAL  = 2'h1, // Amplifier offset calibration
        OCC_ST_CMPCAL  = 2'h3, // Comparator offset calibration
        OCC_ST_INVALID = 2'h2  // Cal mode, flags inconsistent
    } occ_state_t;

endpackage

/* verilog/occ_sync.sv */
`timescale 1ns/10ps
// Two flip-flop level synchroniser
module occ_sync
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic reset_i,
    // Data
    input  wire logic async_i,
    output logic      sync_o
);

    // Stage registers
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    // Next values
    always_comb
    begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    // Register stages
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;

endmodule

/* verilog/occ_top.sv */
`timescale 1ns/10ps
// Over-current front end calibration control
module occ_top
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Analog front end
    input  wire logic        comparator_raw_i,
    output logic      [1:0]  protection_mode_sel_o,
    output logic             amp_cal_mode_o,
    output logic             amp_cal_ref_sel_o,
    output logic      [5:0]  amp_offset_trim_o,
    output logic             cmp_cal_mode_o,
    output logic             cmp_cal_ref_sel_o,
    output logic      [4:0]  cmp_offset_trim_o,
    output logic             amp_cal_active_o,
    output logic             cmp_cal_active_o,
    output logic             comparator_out_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [1:0] mode_q;            // Protection mode
    logic [1:0] mode_d;
    logic       amp_mode_q;        // Amplifier cal flag
    logic       amp_mode_d;
    logic       amp_ref_q;         // Amplifier ref select
    logic       amp_ref_d;
    logic [5:0] amp_trim_q;        // Amplifier trim
    logic [5:0] amp_trim_d;
    logic       cmp_mode_q;        // Comparator cal flag
    logic       cmp_mode_d;
    logic       cmp_ref_q;         // Comparator ref select
    logic       cmp_ref_d;
    logic [4:0] cmp_trim_q;        // Comparator trim
    logic [4:0] cmp_trim_d;
    logic [31:0] rdata_q;          // Read data register
    logic [31:0] rdata_d;
    logic       err_q;             // Error response register
    logic       err_d;
    logic       cmp_sync;          // Synchronised comparator
    logic       cmp_live;          // Gated comparator result
    logic       setup;             // Setup phase of a transfer
    logic       hit;               // Mapped address
    logic       access;            // Access phase of a transfer
    logic       wr_en;             // Write commits this cycle
    logic       sel_ctrl;          // Control register addressed
    logic       sel_amp;           // Amplifier register addressed
    logic       sel_cmp;           // Comparator register addressed
    logic [7:0] rimage;            // Read image of addressed register
    occ_pkg::occ_state_t state_q;  // Operating state
    occ_pkg::occ_state_t state_d;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Mapped address check
    function automatic logic occ_mapped(input logic [7:0] a);
        occ_mapped = (a == occ_pkg::OCC_ADDR_CTRL) ||
                     (a == occ_pkg::OCC_ADDR_AMP)  ||
                     (a == occ_pkg::OCC_ADDR_CMP);
    endfunction

    // ------------------------------------------------------------
    // Comparator synchronisation
    // ------------------------------------------------------------
    // Two stage sync
    occ_sync u_sync
    (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .async_i (comparator_raw_i),
        .sync_o  (cmp_sync)
    );

    assign cmp_live = (mode_q == occ_pkg::OCC_MODE_OFF) ? 1'b0 : cmp_sync;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // Read data and error are captured in the setup phase; writes
    // commit at the edge that completes the access phase, so a
    // register never changes before the master sees the transfer end
    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign wr_en  = access && pwrite && pready;
    assign hit    = occ_mapped(paddr);

    // Address decode, one strobe per register
    always_comb
    begin
        sel_ctrl = 1'b0;
        sel_amp  = 1'b0;
        sel_cmp  = 1'b0;
        if (paddr == occ_pkg::OCC_ADDR_CTRL)
            sel_ctrl = 1'b1;   // Mode control
        else if (paddr == occ_pkg::OCC_ADDR_AMP)
            sel_amp = 1'b1;    // Amplifier calibration
        else if (paddr == occ_pkg::OCC_ADDR_CMP)
            sel_cmp = 1'b1;    // Comparator calibration
    end

    // Read image of the addressed register, upper bits zero
    always_comb
    begin
        rimage = 8'h00;
        if (sel_ctrl)
            rimage[occ_pkg::OCC_CTRL_MODE_LSB +: 2] = mode_q;
        else if (sel_amp)
            rimage = {amp_mode_q, amp_ref_q, amp_trim_q};
        else if (sel_cmp)
            rimage = {cmp_live, cmp_mode_q, cmp_ref_q, cmp_trim_q};
    end

    // Bus response next values, captured in the setup phase
    always_comb
    begin
        rdata_d = rdata_q;
        err_d   = err_q;
        if (setup)
        begin
            // Unmapped address reads zero and flags an error
            rdata_d = {24'h00_0000, rimage};
            err_d   = !hit;
        end
    end

    // Register next values, committed in the access phase
    always_comb
    begin
        mode_d     = mode_q;
        amp_mode_d = amp_mode_q;
        amp_ref_d  = amp_ref_q;
        amp_trim_d = amp_trim_q;
        cmp_mode_d = cmp_mode_q;
        cmp_ref_d  = cmp_ref_q;
        cmp_trim_d = cmp_trim_q;
        if (wr_en && sel_ctrl)
        begin
            // Mode field
            mode_d = pwdata[occ_pkg::OCC_CTRL_MODE_LSB +: 2];
        end
        else if (wr_en && sel_amp)
        begin
            amp_mode_d = pwdata[occ_pkg::OCC_AMP_MODE_BIT];
            amp_ref_d  = pwdata[occ_pkg::OCC_AMP_REF_BIT];
            amp_trim_d = pwdata[5:0];
        end
        else if (wr_en && sel_cmp)
        begin
            cmp_mode_d = pwdata[occ_pkg::OCC_CMP_MODE_BIT];
            cmp_ref_d  = pwdata[occ_pkg::OCC_CMP_REF_BIT];
            cmp_trim_d = pwdata[4:0];
            // Result bit is not stored: writes to it are lost
        end
    end

    // ------------------------------------------------------------
    // Operating state decode
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = occ_pkg::OCC_ST_NORMAL;
        if (mode_d == occ_pkg::OCC_MODE_CAL)
        begin
            if (amp_mode_d && !cmp_mode_d)
                state_d = occ_pkg::OCC_ST_AMPCAL;
            else if (cmp_mode_d && !amp_mode_d)
                state_d = occ_pkg::OCC_ST_CMPCAL;
            else
                state_d = occ_pkg::OCC_ST_INVALID;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            mode_q     <= occ_pkg::OCC_MODE_RST;
            amp_mode_q <= 1'b0;
            amp_ref_q  <= 1'b0;
            amp_trim_q <= occ_pkg::OCC_AMP_TRIM_RST;
            cmp_mode_q <= 1'b0;
            cmp_ref_q  <= 1'b0;
            cmp_trim_q <= occ_pkg::OCC_CMP_TRIM_RST;
            rdata_q    <= 32'h0000_0000;
            err_q      <= 1'b0;
            state_q    <= occ_pkg::OCC_ST_NORMAL;
        end
        else
        begin
            mode_q     <= mode_d;
            amp_mode_q <= amp_mode_d;
            amp_ref_q  <= amp_ref_d;
            amp_trim_q <= amp_trim_d;
            cmp_mode_q <= cmp_mode_d;
            cmp_ref_q  <= cmp_ref_d;
            cmp_trim_q <= cmp_trim_d;
            rdata_q    <= rdata_d;
            err_q      <= err_d;
            state_q    <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Access phase always completes in one cycle
    assign pready  = 1'b1;
    assign prdata  = rdata_q;
    assign pslverr = psel && penable && err_q;

    assign protection_mode_sel_o = mode_q;
    assign amp_cal_mode_o        = amp_mode_q;
    assign amp_cal_ref_sel_o     = amp_ref_q;
    assign amp_offset_trim_o     = amp_trim_q;
    assign cmp_cal_mode_o        = cmp_mode_q;
    assign cmp_cal_ref_sel_o     = cmp_ref_q;
    assign cmp_offset_trim_o     = cmp_trim_q;
    assign amp_cal_active_o      = (state_q == occ_pkg::OCC_ST_AMPCAL);
    assign cmp_cal_active_o      = (state_q == occ_pkg::OCC_ST_CMPCAL);
    assign comparator_out_o      = cmp_live;

endmodule

/* verification/occ_top_monitor.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module occ_top_monitor
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        reset_i,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Front end
    input wire logic        comparator_raw_i,
    input wire logic [1:0]  protection_mode_sel_o,
    input wire logic        amp_cal_mode_o,
    input wire logic [5:0]  amp_offset_trim_o,
    input wire logic        cmp_cal_mode_o,
    input wire logic        cmp_cal_ref_sel_o,
    input wire logic [4:0]  cmp_offset_trim_o,
    input wire logic        amp_cal_active_o,
    input wire logic        cmp_cal_active_o,
    input wire logic        comparator_out_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic wr_s;   // Write access cycle
    logic on_s;   // Protection enabled
    logic cal_s;  // Calibration mode
    assign wr_s  = psel && penable && pwrite;
    assign on_s  = protection_mode_sel_o != 2'h0;
    assign cal_s = protection_mode_sel_o == 2'h3;
    property p_rst;
        $fell(reset_i) |-> cmp_offset_trim_o == 5'h10
            && amp_offset_trim_o == 6'h20;
    endproperty
    property p_cmpw;
        wr_s && paddr == 8'h08 |=> {cmp_cal_mode_o, cmp_cal_ref_sel_o,
            cmp_offset_trim_o} == $past(pwdata[6:0]);
    endproperty
    property p_ampw;
        wr_s && paddr == 8'h04 |=> {amp_cal_mode_o, amp_offset_trim_o}
            == {$past(pwdata[7]), $past(pwdata[5:0])};
    endproperty
    property p_amact;
        $stable({protection_mode_sel_o, amp_cal_mode_o, cmp_cal_mode_o})
            |-> amp_cal_active_o == (cal_s && amp_cal_mode_o
            && !cmp_cal_mode_o);
    endproperty
    property p_cmact;
        $stable({protection_mode_sel_o, amp_cal_mode_o, cmp_cal_mode_o})
            |-> cmp_cal_active_o == (cal_s && cmp_cal_mode_o
            && !amp_cal_mode_o);
    endproperty
    property p_off;
        !on_s |-> !comparator_out_o;
    endproperty
    property p_sync;
        $stable(comparator_raw_i)[*5]
            |-> comparator_out_o == (comparator_raw_i && on_s);
    endproperty
    property p_rd;
        $stable(comparator_raw_i)[*6] ##0 (psel && penable && !pwrite
            && paddr == 8'h08 && on_s) |-> prdata[7] == comparator_out_o;
    endproperty
    a_rst: assert property (p_rst)
        else $error("trim reset value wrong");
    a_cmpw: assert property (p_cmpw)
        else $error("comparator fields not written");
    a_ampw: assert property (p_ampw)
        else $error("amplifier fields not written");
    a_amact: assert property (p_amact)
        else $error("amplifier calibration state wrong");
    a_cmact: assert property (p_cmact)
        else $error("comparator calibration state wrong");
    a_off: assert property (p_off)
        else $error("output high while disabled");
    a_sync: assert property (p_sync)
        else $error("comparator output not following input");
    a_rd: assert property (p_rd)
        else $error("result bit differs from comparator");
    c_amp: cover property (amp_cal_active_o && $rose(comparator_out_o));
    c_cmp: cover property (cmp_cal_active_o && $fell(comparator_out_o));
    c_off: cover property (!on_s && comparator_raw_i);
endmodule

bind occ_top occ_top_monitor mon_u (
    .clk_i(clk_i), .reset_i(reset_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .comparator_raw_i(comparator_raw_i),
    .protection_mode_sel_o(protection_mode_sel_o),
    .amp_cal_mode_o(amp_cal_mode_o), .amp_offset_trim_o(amp_offset_trim_o),
    .cmp_cal_mode_o(cmp_cal_mode_o), .cmp_cal_ref_sel_o(cmp_cal_ref_sel_o),
    .cmp_offset_trim_o(cmp_offset_trim_o),
    .amp_cal_active_o(amp_cal_active_o),
    .cmp_cal_active_o(cmp_cal_active_o),
    .comparator_out_o(comparator_out_o)
);

/* verification/occ_top_tb.sv */
`timescale 1ns/10ps
module occ_top_tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTL = 8'h00; // Mode control
    localparam logic [7:0] A_AMP = 8'h04; // Amplifier cal
    localparam logic [7:0] A_CMP = 8'h08; // Comparator cal
    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        comparator_raw_i = 1'b0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err;
    logic [1:0]  mode;
    logic        amp_m, amp_r, cmp_m, cmp_r, amp_act, cmp_act, cmp_out;
    logic [5:0]  amp_t, v1, v2;
    logic [4:0]  cmp_t;
    int          fails = 0, samples_checked = 0, cycles = 0;

    always #2 clk_i = ~clk_i;

    occ_top dut_u (
        .clk_i(clk_i), .reset_i(reset_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .comparator_raw_i(comparator_raw_i), .protection_mode_sel_o(mode),
        .amp_cal_mode_o(amp_m), .amp_cal_ref_sel_o(amp_r),
        .amp_offset_trim_o(amp_t), .cmp_cal_mode_o(cmp_m),
        .cmp_cal_ref_sel_o(cmp_r), .cmp_offset_trim_o(cmp_t),
        .amp_cal_active_o(amp_act), .cmp_cal_active_o(cmp_act),
        .comparator_out_o(cmp_out)
    );

    // Stand-in comparator trips at a fixed trim in each mode
    always @(posedge clk_i)
    begin
        comparator_raw_i <= amp_act ? (amp_t >= 6'h28) : (cmp_t >= 5'h0D);
    end

    // Hang guard
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails++;
            finish_test;
        end
    end

    task automatic finish_test;
    begin
        if (fails == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask

    task automatic chk(input string n, input logic [31:0] got, exp);
    begin
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s exp %h got %h", n, exp, got);
        end
    end
    endtask

    // One APB transfer, then let outputs settle
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
    begin
        @(posedge clk_i);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    end
    endtask

    // Write a trim, wait for the comparator, read the result bit
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    begin
        apb(1'b1, a, {24'h0, d});
        repeat (3) @(posedge clk_i);
        apb(1'b0, A_CMP, 32'h0);
    end
    endtask

    // Software sweep up from zero, down from full scale, midpoint
    task automatic sweep(input logic [7:0] a, input logic [7:0] base,
                         input logic [5:0] top, output logic [5:0] up,
                         output logic [5:0] dn);
        logic       b0;
        logic [6:0] mid;
    begin
        up = 6'h00;
        wr_rd(a, base);
        b0 = rd[7];
        do
        begin
            up = up + 6'h01;
            wr_rd(a, base | {2'h0, up});
        end
        while (rd[7] === b0 && up != top);
        dn = top;
        wr_rd(a, base | {2'h0, dn});
        b0 = rd[7];
        do
        begin
            dn = dn - 6'h01;
            wr_rd(a, base | {2'h0, dn});
        end
        while (rd[7] === b0 && dn != 6'h00);
        mid = ({1'b0, up} + {1'b0, dn}) >> 1;
        apb(1'b1, a, {24'h0, base | {1'b0, mid}});
    end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        apb(1'b0, A_AMP, 32'h0);
        chk("amp reset", rd, 32'h20);
        apb(1'b0, A_CMP, 32'h0);
        chk("cmp reset", rd & 32'h7F, 32'h10);
        chk("mapped err", {31'h0, err}, 32'h0);
        apb(1'b1, A_CMP, 32'hFF);
        apb(1'b0, A_CMP, 32'h0);
        chk("cmp fields", rd & 32'h7F, 32'h7F);
        chk("cmp ports", {25'h0, cmp_m, cmp_r, cmp_t}, 32'h7F);
        apb(1'b1, A_CMP, 32'h10);
        apb(1'b1, A_CTL, 32'h3);
        sweep(A_AMP, 8'h80, 6'h3F, v1, v2);
        chk("amp up", {26'h0, v1}, 32'd40);
        chk("amp down", {26'h0, v2}, 32'd39);
        chk("amp mid", {26'h0, amp_t}, 32'd39);
        chk("amp state", {30'h0, amp_act, cmp_act}, 32'h2);
        apb(1'b1, A_AMP, 32'h27);
        sweep(A_CMP, 8'h40, 6'h1F, v1, v2);
        chk("cmp up", {26'h0, v1}, 32'd13);
        chk("cmp down", {26'h0, v2}, 32'd12);
        chk("cmp mid", {27'h0, cmp_t}, 32'd12);
        chk("cmp state", {30'h0, amp_act, cmp_act}, 32'h1);
        apb(1'b1, A_AMP, 32'hA7);
        chk("both flags", {30'h0, amp_act, cmp_act}, 32'h0);
        apb(1'b1, A_AMP, 32'h67);
        apb(1'b0, A_AMP, 32'h0);
        chk("amp read", rd, 32'h67);
        chk("amp ref", {31'h0, amp_r}, 32'h1);
        apb(1'b1, A_CMP, 32'h1F);
        for (int m = 0; m < 4; m++)
        begin
            apb(1'b1, A_CTL, m);
            repeat (3) @(posedge clk_i);
            #1;
            chk("mode", {30'h0, mode}, m);
            chk("cmp out", {31'h0, cmp_out}, m != 0);
        end
        apb(1'b0, A_CMP, 32'h0);
        chk("result bit", {31'h0, rd[7]}, 32'h1);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        finish_test;
    end
endmodule
